// *** hdl/dbc_cache.sv ***
// disk buffer cache controller: segmented write cache with look-ahead and flush
// assumes host, media engine and register master are synchronous logic on MCLK
//
// How it works
// [R1] with read caching on, blocks written to medium stay valid in cache
// [R2] segment allocation ignores the read cache setting; writes share read segments
// [R3] each write block first clears any other cached copy of that block
// [R4] written blocks become readable hits for later read commands
// [R5] write past segment end wraps to the start of the same segment
// [R6] a slot holding unflushed data of another block stalls write storage and skips read fills instead of being overwritten
// [R7] with write-back on, write completes once all blocks sit in cache
// [R8] media write failure after good completion raises a sticky deferred error
// [R9] sync command drains every dirty block to the medium
// [R10] sync completes good only when no dirty block remains; a failed media write ends it with DONE_OK low
// [R11] look-ahead fetches blocks after a read even with read caching off
// [R12] hits on look-ahead data are flagged and counted apart from cache hits
// [R13] lookahead_off lives in page byte 12 bit 5; zero enables look-ahead
// [R14] look-ahead maximum and ceiling bytes are ignored and read zero
// [R15] look-ahead turns on for sequential reads, off for scattered ones
// [R16] reads search the cache before any medium access
// [R17] segments are circular, block granular, allocated round robin per command
// [R18] segment size reads all ones; writes to it change nothing
// [R19] a dirty block clears only after its media write succeeds, or when a newer write of that block drops the older copy
`timescale 1ns/1ps

// ----
// write data fifo
// ----
module dbc_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk, // clock
  input wire logic rst_n, // synchronised reset, low active
  input wire logic in_valid, // source offers a word
  output logic in_ready, // room for a word
  input wire logic [W-1:0] in_data, // incoming word
  output logic out_valid, // a word is waiting
  input wire logic out_ready, // sink takes the word
  output logic [W-1:0] out_data // oldest word
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] buf_mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count != '0);
  assign out_data = buf_mem[rp];
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk) begin
    if (push) begin
      buf_mem[wp] <= in_data;
    end
  end

  // depth is a power of two, so pointers wrap by overflow
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
      count <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wp <= wp + 1'b1;
      end
      if (pop) begin
        rp <= rp + 1'b1;
      end
      count <= next_count;
      in_ready <= (next_count != (AW+1)'(DEPTH));
    end
  end
endmodule // dbc_fifo

// ----
// cache controller top
// ----
module dbc_cache
  import dbc_pkg::*;
(
  input wire logic MCLK, // 200 MHz clock
  input wire logic RSTN, // asynchronous reset, low active
  input wire logic [7:0] REG_ADDR, // register address
  input wire logic [7:0] REG_WDATA, // register write data
  input wire logic REG_WR, // register write strobe
  input wire logic REG_RD, // register read strobe
  output logic [7:0] REG_RDATA, // read data, cycle after REG_RD
  input wire dbc_cmd_t CMD, // command opcode, start block, block count
  input wire logic CMD_VALID, // command offered
  output logic CMD_READY, // command accepted when high with CMD_VALID
  output logic DONE, // command completion pulse
  output logic DONE_OK, // completion status, valid with DONE
  output logic DEFERRED_ERR, // sticky deferred write error
  input wire logic [DW-1:0] WDATA, // host write block
  input wire logic WVALID, // host write block offered
  output logic WREADY, // write buffer has room
  output dbc_rdout_t RD_OUT, // read block with hit class
  output logic RVALID, // RD_OUT valid pulse
  output logic MED_WR_REQ, // media write request, held to ack
  output logic [LW-1:0] MED_WR_LBA, // media write block address
  output logic [DW-1:0] MED_WR_DATA, // media write block
  input wire logic MED_WR_ACK, // media write finished pulse
  input wire logic MED_WR_ERR, // media write failed, with ack
  output logic MED_RD_REQ, // media read request, held to data
  output logic [LW-1:0] MED_RD_LBA, // media read block address
  input wire logic [DW-1:0] MED_RD_DATA, // media read block
  input wire logic MED_RD_VALID // media read data pulse
);

  // ----
  // reset release
  // ----
  logic rst_q1;
  logic rst_n;

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // ----
  // declarations
  // ----
  dbc_state_t state;
  logic read_cache_off;
  logic write_back_on;
  logic lookahead_off;
  logic [DW-1:0] mem [NSLOT];
  logic [LW-1:0] slot_tag [NSLOT];
  logic [NSLOT-1:0] valid;
  logic [NSLOT-1:0] dirty;
  logic [NSLOT-1:0] pf;
  logic [LW-1:0] cur_lba;
  logic [LW-1:0] next_seq_lba;
  logic [CW-1:0] left;
  logic [SGW-1:0] seg;
  logic [SGW-1:0] rr_seg;
  logic pf_mode;
  logic had_miss;
  logic [1:0] la_score;
  logic [7:0] cache_hits;
  logic [7:0] pf_hits;
  logic fl_busy;
  logic [SLW-1:0] fl_idx;
  logic hit;
  logic hit_pf;
  logic [SLW-1:0] hit_slot;
  logic fd_found;
  logic [SLW-1:0] fd_idx;
  logic [SLW-1:0] tgt;
  logic tgt_blocked;
  logic fifo_valid;
  logic [DW-1:0] fifo_data;
  logic fifo_pop;
  logic rd_fill;
  logic fl_ack;
  logic fl_ack_err;
  logic any_dirty;
  logic take;
  logic read_end;
  logic pf_start;
  logic la_active;

  // ------------------------------------------------------------------------
  // write buffer
  // ------------------------------------------------------------------------
  dbc_fifo #(
    .W(DW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(MCLK),
    .rst_n(rst_n),
    .in_valid(WVALID),
    .in_ready(WREADY),
    .in_data(WDATA),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // ------------------------------------------------------------------------
  // lookup and events
  // ------------------------------------------------------------------------
  always_comb begin
    logic [SLW-1:0] sl;
    sl = '0;
    hit = 1'b0;
    hit_pf = 1'b0;
    hit_slot = '0;
    fd_found = 1'b0;
    fd_idx = '0;
    for (int s = 0; s < NSEG; s++) begin
      sl = {SGW'(s), cur_lba[SIW-1:0]};
      // dirty copies always hit so reads never see stale medium data
      if (valid[sl] && slot_tag[sl] == cur_lba &&
          (!read_cache_off || pf[sl] || dirty[sl])) begin // R16 R11
        hit = 1'b1;
        hit_pf = pf[sl] && !dirty[sl];
        hit_slot = sl;
      end
    end
    for (int i = NSLOT - 1; i >= 0; i--) begin
      if (dirty[i]) begin
        fd_found = 1'b1;
        fd_idx = SLW'(i);
      end
    end
  end

  assign tgt = {seg, cur_lba[SIW-1:0]}; // R5 R17
  assign tgt_blocked = (dirty[tgt] && slot_tag[tgt] != cur_lba) ||
                       (fl_busy && fl_idx == tgt); // R6
  assign fifo_pop = (state == ST_WR) && (left != '0) && fifo_valid && !tgt_blocked;
  assign rd_fill = (state == ST_RDWAIT) && MED_RD_VALID && !dirty[tgt]; // R6
  assign fl_ack = fl_busy && MED_WR_ACK;
  assign fl_ack_err = fl_ack && MED_WR_ERR;
  assign any_dirty = |dirty;
  assign take = (state == ST_IDLE) && CMD_VALID && CMD_READY;
  assign read_end = (state == ST_RD) && (left == '0);
  assign la_active = !lookahead_off && (la_score >= LA_ON_LEVEL);
  assign pf_start = read_end && la_active && had_miss; // R11 R15

  // ------------------------------------------------------------------------
  // mode settings
  // ------------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      read_cache_off <= RST_READ_CACHE_OFF;
      write_back_on <= RST_WRITE_BACK_ON;
      lookahead_off <= RST_LOOKAHEAD_OFF;
    end else if (REG_WR) begin
      case (REG_ADDR)
        OFF_CACHE_CTL: begin
          read_cache_off <= REG_WDATA[BIT_READ_CACHE_OFF];
          write_back_on <= REG_WDATA[BIT_WRITE_BACK_ON];
        end
        OFF_LA_CTL: lookahead_off <= REG_WDATA[BIT_LOOKAHEAD_OFF]; // R13
        default: ; // R14 R18
      endcase
    end
  end

  // ------------------------------------------------------------------------
  // register reads
  // ------------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      REG_RDATA <= 8'h00;
      case (REG_ADDR)
        OFF_CACHE_CTL: begin
          REG_RDATA[BIT_READ_CACHE_OFF] <= read_cache_off;
          REG_RDATA[BIT_WRITE_BACK_ON] <= write_back_on;
        end
        OFF_LA_CTL: REG_RDATA[BIT_LOOKAHEAD_OFF] <= lookahead_off; // R13
        OFF_SEGSZ_HI, OFF_SEGSZ_LO: REG_RDATA <= SEGSZ_BYTE; // R18
        OFF_STATUS: begin
          REG_RDATA[BIT_DEFER_ERR] <= DEFERRED_ERR;
          REG_RDATA[BIT_BUSY] <= (state != ST_IDLE) || any_dirty;
          REG_RDATA[BIT_LA_ACTIVE] <= la_active;
        end
        OFF_CACHE_HITS: REG_RDATA <= cache_hits;
        OFF_PF_HITS: REG_RDATA <= pf_hits;
        default: REG_RDATA <= 8'h00; // R14
      endcase
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

  // ------------------------------------------------------------------------
  // deferred error flag, a new failure beats a same-cycle clear
  // ------------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      DEFERRED_ERR <= 1'b0;
    end else if (fl_ack_err && state != ST_WRWAIT && state != ST_SYNC) begin
      DEFERRED_ERR <= 1'b1; // R8
    end else if (REG_WR && REG_ADDR == OFF_STATUS && REG_WDATA[BIT_DEFER_ERR]) begin
      DEFERRED_ERR <= 1'b0;
    end
  end

  // ------------------------------------------------------------------------
  // block storage
  // ------------------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (fifo_pop) begin
      mem[tgt] <= fifo_data; // R4
      slot_tag[tgt] <= cur_lba;
    end else if (rd_fill) begin
      mem[tgt] <= MED_RD_DATA;
      slot_tag[tgt] <= cur_lba;
    end
  end

  // ------------------------------------------------------------------------
  // slot state: valid, dirty, look-ahead origin
  // ------------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      valid <= '0;
      dirty <= '0;
      pf <= '0;
    end else begin
      if (fl_ack && !MED_WR_ERR) begin
        dirty[fl_idx] <= 1'b0; // R19
        if (read_cache_off) begin
          valid[fl_idx] <= 1'b0; // R1
        end
      end
      if (fifo_pop) begin
        for (int s = 0; s < NSEG; s++) begin
          if (SGW'(s) != seg && slot_tag[{SGW'(s), cur_lba[SIW-1:0]}] == cur_lba) begin
            valid[{SGW'(s), cur_lba[SIW-1:0]}] <= 1'b0; // R3
            dirty[{SGW'(s), cur_lba[SIW-1:0]}] <= 1'b0; // R3
            pf[{SGW'(s), cur_lba[SIW-1:0]}] <= 1'b0;
          end
        end
        valid[tgt] <= 1'b1; // R4
        dirty[tgt] <= 1'b1;
        pf[tgt] <= 1'b0;
      end
      if (rd_fill) begin
        valid[tgt] <= 1'b1;
        pf[tgt] <= pf_mode; // R12
      end
    end
  end

  // ------------------------------------------------------------------------
  // background flusher, one block in flight
  // ------------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      fl_busy <= 1'b0;
      fl_idx <= '0;
      MED_WR_REQ <= 1'b0;
      MED_WR_LBA <= '0;
      MED_WR_DATA <= '0;
    end else if (fl_busy) begin
      if (MED_WR_ACK) begin
        fl_busy <= 1'b0;
        MED_WR_REQ <= 1'b0;
      end
    end else if (fd_found && !(fifo_pop && tgt == fd_idx)) begin // R9
      // a failed block stays dirty and is picked again
      fl_busy <= 1'b1;
      fl_idx <= fd_idx;
      MED_WR_REQ <= 1'b1;
      MED_WR_LBA <= slot_tag[fd_idx];
      MED_WR_DATA <= mem[fd_idx];
    end
  end

  // ------------------------------------------------------------------------
  // look-ahead scoring and hit statistics
  // ------------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      la_score <= RST_LA_SCORE;
      next_seq_lba <= '0;
      cache_hits <= 8'h00;
      pf_hits <= 8'h00;
    end else begin
      if (take && CMD.op == OP_READ) begin
        if (CMD.lba == next_seq_lba) begin
          if (la_score != LA_SCORE_MAX) begin
            la_score <= la_score + 1'b1; // R15
          end
        end else if (la_score != 2'h0) begin
          la_score <= la_score - 1'b1; // R15
        end
      end
      if (read_end) begin
        next_seq_lba <= cur_lba;
      end
      if (state == ST_RD && left != '0 && hit) begin
        if (hit_pf) begin
          pf_hits <= pf_hits + 1'b1; // R12
        end else begin
          cache_hits <= cache_hits + 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------------------
  // command sequencer
  // ------------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      CMD_READY <= 1'b0;
      DONE <= 1'b0;
      DONE_OK <= 1'b0;
      RVALID <= 1'b0;
      RD_OUT <= '0;
      MED_RD_REQ <= 1'b0;
      MED_RD_LBA <= '0;
      cur_lba <= '0;
      left <= '0;
      seg <= '0;
      rr_seg <= '0;
      pf_mode <= 1'b0;
      had_miss <= 1'b0;
    end else begin
      DONE <= 1'b0;
      RVALID <= 1'b0;
      case (state)
        ST_IDLE: begin
          CMD_READY <= 1'b1;
          if (take) begin
            CMD_READY <= 1'b0;
            cur_lba <= CMD.lba;
            left <= CMD.cnt;
            seg <= rr_seg; // R2 R17
            rr_seg <= rr_seg + 1'b1;
            pf_mode <= 1'b0;
            had_miss <= 1'b0;
            case (CMD.op)
              OP_WRITE: state <= ST_WR;
              OP_SYNC: state <= ST_SYNC;
              default: state <= ST_RD;
            endcase
          end
        end
        ST_WR: begin
          if (left == '0) begin
            if (write_back_on) begin
              DONE <= 1'b1; // R7
              DONE_OK <= 1'b1;
              state <= ST_IDLE;
            end else begin
              state <= ST_WRWAIT;
            end
          end else if (fifo_pop) begin
            cur_lba <= cur_lba + 1'b1;
            left <= left - 1'b1;
          end
        end
        ST_WRWAIT, ST_SYNC: begin
          if (fl_ack_err) begin
            DONE <= 1'b1;
            DONE_OK <= 1'b0;
            state <= ST_IDLE;
          end else if (!any_dirty) begin
            DONE <= 1'b1; // R10
            DONE_OK <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_RD, ST_PF: begin
          if (left == '0) begin
            if (state == ST_RD) begin
              DONE <= 1'b1;
              DONE_OK <= 1'b1;
            end
            if (pf_start) begin
              state <= ST_PF; // R11
              left <= PF_BLKS;
              pf_mode <= 1'b1;
            end else begin
              state <= ST_IDLE;
              pf_mode <= 1'b0;
            end
          end else if (hit) begin
            if (state == ST_RD) begin
              RVALID <= 1'b1; // R16
              RD_OUT <= '{data: mem[hit_slot], cache_hit: !hit_pf, pf_hit: hit_pf}; // R12
            end
            cur_lba <= cur_lba + 1'b1;
            left <= left - 1'b1;
          end else begin
            MED_RD_REQ <= 1'b1;
            MED_RD_LBA <= cur_lba;
            had_miss <= 1'b1;
            state <= ST_RDWAIT;
          end
        end
        ST_RDWAIT: begin
          if (MED_RD_VALID) begin
            MED_RD_REQ <= 1'b0;
            cur_lba <= cur_lba + 1'b1;
            left <= left - 1'b1;
            if (pf_mode) begin
              state <= ST_PF;
            end else begin
              RVALID <= 1'b1;
              RD_OUT <= '{data: MED_RD_DATA, cache_hit: 1'b0, pf_hit: 1'b0};
              state <= ST_RD;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule // dbc_cache

// *** hdl/dbc_pkg.sv ***
// shared constants and types of the disk buffer cache controller
// assumes one clock domain; host, media engine and register master all run on that clock
package dbc_pkg;

  // ----
  // geometry
  // ----
  localparam int DW = 32;
  localparam int LW = 16;
  localparam int CW = 4;
  localparam int NSEG = 4;
  localparam int SGW = 2;
  localparam int SEGB = 8;
  localparam int SIW = 3;
  localparam int NSLOT = NSEG * SEGB;
  localparam int SLW = SGW + SIW;
  localparam int FIFO_DEPTH = 16;
  localparam logic [CW-1:0] PF_BLKS = 4'h4;

  // ----
  // register offsets (caching mode page bytes, then status)
  // ----
  localparam logic [7:0] OFF_CACHE_CTL = 8'h02;
  localparam logic [7:0] OFF_LA_MAX_HI = 8'h08;
  localparam logic [7:0] OFF_LA_MAX_LO = 8'h09;
  localparam logic [7:0] OFF_LA_CEIL_HI = 8'h0a;
  localparam logic [7:0] OFF_LA_CEIL_LO = 8'h0b;
  localparam logic [7:0] OFF_LA_CTL = 8'h0c;
  localparam logic [7:0] OFF_SEGSZ_HI = 8'h0e;
  localparam logic [7:0] OFF_SEGSZ_LO = 8'h0f;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_CACHE_HITS = 8'h21;
  localparam logic [7:0] OFF_PF_HITS = 8'h22;

  // ----
  // field positions
  // ----
  localparam int BIT_READ_CACHE_OFF = 0;
  localparam int BIT_WRITE_BACK_ON = 2;
  localparam int BIT_LOOKAHEAD_OFF = 5;
  localparam int BIT_DEFER_ERR = 0;
  localparam int BIT_BUSY = 1;
  localparam int BIT_LA_ACTIVE = 2;

  // ----
  // reset values and fixed answers
  // ----
  localparam logic RST_READ_CACHE_OFF = 1'b0;
  localparam logic RST_WRITE_BACK_ON = 1'b1;
  localparam logic RST_LOOKAHEAD_OFF = 1'b0;
  localparam logic [1:0] RST_LA_SCORE = 2'h2;
  localparam logic [1:0] LA_ON_LEVEL = 2'h2;
  localparam logic [1:0] LA_SCORE_MAX = 2'h3;
  localparam logic [7:0] SEGSZ_BYTE = 8'hff;

  // ----
  // types
  // ----
  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_WRITE = 2'h1,
    OP_SYNC = 2'h2
  } dbc_op_t;

  typedef struct packed {
    dbc_op_t op;
    logic [LW-1:0] lba;
    logic [CW-1:0] cnt;
  } dbc_cmd_t;

  typedef struct packed {
    logic [DW-1:0] data;
    logic cache_hit;
    logic pf_hit;
  } dbc_rdout_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RD = 3'h1,
    ST_RDWAIT = 3'h3,
    ST_PF = 3'h2,
    ST_WR = 3'h4,
    ST_WRWAIT = 3'h5,
    ST_SYNC = 3'h6
  } dbc_state_t;

endpackage

// *** test/dbc_cache_bench.sv ***
// self-checking bench for the buffer cache controller
// assumes dbc_media stands on the media side
`timescale 1ns/1ps
module dbc_cache_bench;
  import dbc_pkg::*;
  logic MCLK = 1'b0, RSTN = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, CMD_VALID = 1'b0, WVALID = 1'b0;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA;
  dbc_cmd_t CMD = '0;
  logic [DW-1:0] WDATA = '0, MED_WR_DATA, MED_RD_DATA;
  logic [LW-1:0] MED_WR_LBA, MED_RD_LBA;
  logic CMD_READY, DONE, DONE_OK, DEFERRED_ERR, WREADY, RVALID, fail = 1'b0;
  logic MED_WR_REQ, MED_WR_ACK, MED_WR_ERR, MED_RD_REQ, MED_RD_VALID;
  dbc_rdout_t RD_OUT, last;
  int failures = 0, compares = 0, ok_cnt, n;
  dbc_cache dbc_cache_inst (.*);
  dbc_media dbc_media_inst (.clk(MCLK), .rst_n(RSTN), .lag(8'h08), .fail, .wr_req(MED_WR_REQ),
    .wr_ack(MED_WR_ACK), .wr_err(MED_WR_ERR), .rd_req(MED_RD_REQ), .rd_lba(MED_RD_LBA),
    .rd_data(MED_RD_DATA), .rd_valid(MED_RD_VALID), .ok_cnt);
  always #2.5 MCLK = ~MCLK;
  always @(negedge MCLK) if (RVALID === 1'b1) last = RD_OUT;
  // ----
  // access tasks
  // ----
  task end_sim;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [DW+1:0] seen, input logic [DW+1:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task tick;
    @(negedge MCLK);
    n++;
    if (n > 3000) begin
      failures++;
      end_sim();
    end
  endtask
  task reg_io(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge MCLK);
    REG_WR <= wr;
    REG_RD <= !wr;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge MCLK);
    REG_WR <= 1'b0;
    REG_RD <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    reg_io(1'b0, a, 8'h00);
    chk(REG_RDATA, e);
  endtask
  task push(input logic [DW-1:0] d);
    @(posedge MCLK);
    WVALID <= 1'b1;
    WDATA <= d;
    n = 0;
    do tick(); while (WREADY !== 1'b1);
    @(posedge MCLK);
    WVALID <= 1'b0;
  endtask
  task cmd(input dbc_op_t op, input logic [LW-1:0] lba, input logic [CW-1:0] cnt);
    n = 0;
    while (CMD_READY !== 1'b1) tick();
    @(posedge MCLK);
    CMD <= '{op, lba, cnt};
    CMD_VALID <= 1'b1;
    @(posedge MCLK);
    CMD_VALID <= 1'b0;
  endtask
  task done(input logic ok);
    n = 0;
    while (DONE !== 1'b1) tick();
    chk(DONE_OK, ok);
  endtask
  initial begin
    repeat (6) @(posedge MCLK);
    RSTN <= 1'b1;
    repeat (4) @(posedge MCLK);
    rd(OFF_CACHE_CTL, 8'h04);
    reg_io(1'b1, OFF_SEGSZ_HI, 8'h12);
    rd(OFF_SEGSZ_HI, SEGSZ_BYTE);
    rd(OFF_SEGSZ_LO, SEGSZ_BYTE);
    for (int a = 8; a < 12; a++) begin
      reg_io(1'b1, 8'(a), 8'hff);
      rd(8'(a), 8'h00);
    end
    reg_io(1'b1, OFF_LA_CTL, 8'h20);
    rd(OFF_LA_CTL, 8'h20);
    reg_io(1'b1, OFF_LA_CTL, 8'h00);
    rd(8'h30, 8'h00);
    $display("end of register test");
    push(32'h1111_0010);
    push(32'h1111_0011);
    cmd(OP_WRITE, 16'h0010, 4'h2);
    done(1'b1);
    chk(ok_cnt, 0);
    cmd(OP_SYNC, 16'h0000, 4'h0);
    done(1'b1);
    chk(ok_cnt, 2);
    push(32'h2222_0011);
    cmd(OP_WRITE, 16'h0011, 4'h1);
    done(1'b1);
    cmd(OP_READ, 16'h0010, 4'h1);
    done(1'b1);
    chk(last, {32'h1111_0010, 2'b10});
    cmd(OP_READ, 16'h0011, 4'h1);
    done(1'b1);
    chk(last, {32'h2222_0011, 2'b10});
    for (int i = 0; i < 9; i++) push(32'h3333_0020 + i);
    cmd(OP_WRITE, 16'h0020, 4'h9);
    done(1'b1);
    cmd(OP_READ, 16'h0028, 4'h1);
    done(1'b1);
    chk(last, {32'h3333_0028, 2'b10});
    cmd(OP_SYNC, 16'h0000, 4'h0);
    done(1'b1);
    chk(ok_cnt, 12);
    $display("end of write cache test");
    reg_io(1'b1, OFF_CACHE_CTL, 8'h00);
    push(32'h4444_0030);
    cmd(OP_WRITE, 16'h0030, 4'h1);
    done(1'b1);
    chk(ok_cnt, 13);
    reg_io(1'b1, OFF_CACHE_CTL, 8'h04);
    fail <= 1'b1;
    push(32'h5555_0031);
    cmd(OP_WRITE, 16'h0031, 4'h1);
    done(1'b1);
    n = 0;
    while (DEFERRED_ERR !== 1'b1) tick();
    @(posedge MCLK);
    fail <= 1'b0;
    cmd(OP_SYNC, 16'h0000, 4'h0);
    done(1'b1);
    chk(ok_cnt, 14);
    reg_io(1'b1, OFF_STATUS, 8'h01);
    reg_io(1'b0, OFF_STATUS, 8'h00);
    chk(REG_RDATA[BIT_DEFER_ERR], 1'b0);
    $display("end of error test");
    reg_io(1'b1, OFF_CACHE_CTL, 8'h05);
    for (int i = 0; i < 4; i++) begin
      cmd(OP_READ, 16'h0050 + 16'(i), 4'h1);
      done(1'b1);
    end
    reg_io(1'b0, OFF_STATUS, 8'h00);
    chk(REG_RDATA[BIT_LA_ACTIVE], 1'b1);
    cmd(OP_READ, 16'h0060, 4'h1);
    done(1'b1);
    chk(last, {32'hff9f_0060, 2'b00});
    cmd(OP_READ, 16'h0061, 4'h1);
    done(1'b1);
    chk(last, {32'hff9e_0061, 2'b01});
    for (int i = 0; i < 3; i++) begin
      cmd(OP_READ, 16'h0030 + 16'(i) * 16'h0040, 4'h1);
      done(1'b1);
    end
    reg_io(1'b0, OFF_STATUS, 8'h00);
    chk(REG_RDATA[BIT_LA_ACTIVE], 1'b0);
    $display("end of look-ahead test");
    end_sim();
  end
endmodule // dbc_cache_bench

// *** test/dbc_cache_properties.sv ***
// port checker for the buffer cache controller
// assumes binding to dbc_cache, one clock MCLK
`timescale 1ns/1ps
module dbc_cache_properties
  import dbc_pkg::*;
(
  input wire logic MCLK, // clock
  input wire logic RSTN, // reset, low active
  input wire logic [7:0] REG_ADDR, // address
  input wire logic [7:0] REG_WDATA, // write data
  input wire logic REG_WR, // write strobe
  input wire logic REG_RD, // read strobe
  input wire logic [7:0] REG_RDATA, // read data
  input wire logic DEFERRED_ERR, // sticky error
  input wire dbc_rdout_t RD_OUT, // read block
  input wire logic RVALID, // read pulse
  input wire logic MED_WR_REQ, // media write
  input wire logic [LW-1:0] MED_WR_LBA, // write address
  input wire logic [DW-1:0] MED_WR_DATA, // write block
  input wire logic MED_WR_ACK, // write answer
  input wire logic MED_RD_REQ, // media read
  input wire logic [LW-1:0] MED_RD_LBA, // read address
  input wire logic MED_RD_VALID // read answer
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  property p_segsz;
    REG_RD && REG_ADDR == OFF_SEGSZ_HI |=> REG_RDATA == SEGSZ_BYTE;
  endproperty
  a_segsz: assert property (p_segsz) else $error("segment size");
  property p_lamax;
    REG_RD && REG_ADDR inside {[OFF_LA_MAX_HI:OFF_LA_CEIL_LO]} |=> REG_RDATA == 8'h00;
  endproperty
  a_lamax: assert property (p_lamax) else $error("look-ahead limits");
  property p_lactl;
    REG_WR && REG_ADDR == OFF_LA_CTL ##1 !REG_WR ##1 REG_RD && REG_ADDR == OFF_LA_CTL
      |=> REG_RDATA[BIT_LOOKAHEAD_OFF] == $past(REG_WDATA[BIT_LOOKAHEAD_OFF], 3);
  endproperty
  a_lactl: assert property (p_lactl) else $error("look-ahead bit");
  property p_wrhold;
    MED_WR_REQ && !MED_WR_ACK |=> MED_WR_REQ && $stable(MED_WR_LBA) && $stable(MED_WR_DATA);
  endproperty
  a_wrhold: assert property (p_wrhold) else $error("media write dropped");
  property p_rdhold;
    MED_RD_REQ && !MED_RD_VALID |=> MED_RD_REQ && $stable(MED_RD_LBA);
  endproperty
  a_rdhold: assert property (p_rdhold) else $error("media read dropped");
  property p_sticky;
    DEFERRED_ERR && !(REG_WR && REG_ADDR == OFF_STATUS && REG_WDATA[BIT_DEFER_ERR]) |=> DEFERRED_ERR;
  endproperty
  a_sticky: assert property (p_sticky) else $error("deferred error lost");
  property p_class;
    RVALID |-> !(RD_OUT.cache_hit && RD_OUT.pf_hit);
  endproperty
  a_class: assert property (p_class) else $error("double hit class");
  property p_search;
    RVALID && (RD_OUT.cache_hit || RD_OUT.pf_hit) |-> !$past(MED_RD_VALID);
  endproperty
  a_search: assert property (p_search) else $error("hit after media read");
endmodule // dbc_cache_properties

bind dbc_cache dbc_cache_properties dbc_cache_properties_inst (.*);

// *** test/dbc_media.sv ***
// media model: answers each held request after a set lag
// assumes requests stay up until answered
`timescale 1ns/1ps
module dbc_media
  import dbc_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst_n, // reset, low active
  input wire logic [7:0] lag, // answer delay
  input wire logic fail, // fail write answers
  input wire logic wr_req, // write request
  output logic wr_ack, // write answer
  output logic wr_err, // write failed
  input wire logic rd_req, // read request
  input wire logic [LW-1:0] rd_lba, // read address
  output logic [DW-1:0] rd_data, // read block
  output logic rd_valid, // read answer
  output int ok_cnt // count of good block writes, rewrites of a block counted again
);
  int wt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ack <= 1'b0;
      wr_err <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= '0;
      wt <= 0;
      ok_cnt <= 0;
    end else begin
      wr_ack <= 1'b0;
      wr_err <= 1'b0;
      rd_valid <= 1'b0;
      // data lines never keep a stale block
      rd_data <= ~rd_data;
      wt <= (wr_req || rd_req) ? wt + 1 : 0;
      if (wt >= lag && wr_req && !wr_ack) begin
        wr_ack <= 1'b1;
        wr_err <= fail;
        wt <= 0;
        ok_cnt <= ok_cnt + (fail ? 0 : 1);
      end else if (wt >= lag && rd_req && !rd_valid) begin
        rd_valid <= 1'b1;
        rd_data <= {~rd_lba, rd_lba};
        wt <= 0;
      end
    end
  end
endmodule // dbc_media
